// ### verilog/ssd_pkg.sv
// Constants, codes and types for the scanner status display and scan gating
package ssd_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLOCK_HZ    = 50_000_000;
	localparam int SCAN_MS     = 30;
	localparam int SCAN_CYCLES = CLOCK_HZ / 1000 * SCAN_MS;
	localparam int HOLD_S      = 3;
	localparam int HOLD_CYCLES = CLOCK_HZ * HOLD_S;
	localparam int INIT_SCANS  = 4;

	// ------------------------------------------------------------
	// Register map and fields
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_IP     = 8'h08;
	localparam logic [7:0] ADDR_GW     = 8'h0c;
	localparam logic [7:0] ADDR_MASK   = 8'h10;
	localparam logic [7:0] ADDR_PORT   = 8'h14;
	localparam int         CTRL_INV    = 0;
	localparam int         CTRL_LOFF   = 1;
	localparam int         CTRL_SKIP   = 2;
	localparam logic [3:0] CTRL_RESET  = 4'h0;

	// ------------------------------------------------------------
	// Factory network settings
	// ------------------------------------------------------------
	localparam logic [31:0] FACT_IP   = 32'hc0a8000a;
	localparam logic [31:0] FACT_GW   = 32'hc0a80001;
	localparam logic [31:0] FACT_MASK = 32'hffffff00;
	localparam logic [15:0] FACT_PORT = 16'h2abc;

	// ------------------------------------------------------------
	// Display codes
	// ------------------------------------------------------------
	localparam logic [7:0] CODE_INIT  = 8'h00;
	localparam logic [7:0] CODE_ILK1  = 8'h34;
	localparam logic [7:0] CODE_ILK2  = 8'h35;
	localparam logic [7:0] CODE_ILK12 = 8'h36;
	localparam logic [7:0] CODE_MUT1  = 8'h37;
	localparam logic [7:0] CODE_MUT2  = 8'h38;
	localparam logic [7:0] CODE_MUT12 = 8'h39;
	localparam logic [7:0] CODE_LOFF  = 8'h40;
	localparam logic [7:0] CODE_FOUND = 8'hf2;
	localparam logic [7:0] CODE_APPLY = 8'hf3;
	localparam logic [7:0] CODE_DONE  = 8'hf4;
	localparam logic [7:0] CODE_REST  = 8'hf5;
	localparam logic [7:0] CODE_ADDR  = 8'hfb;
	localparam logic [3:0] ERR_DIGIT  = 4'he;
	localparam logic [5:0] LOFF_AREA  = 6'h01;
	localparam logic [5:0] MAX_AREA   = 6'h20;

	typedef enum logic [2:0] {
		PH_INIT  = 3'h0,
		PH_RUN   = 3'h1,
		PH_FOUND = 3'h2,
		PH_APPLY = 3'h3,
		PH_DONE  = 3'h4,
		PH_REST  = 3'h5,
		PH_ADDR  = 3'h6
	} ssd_phase_e;

endpackage : ssd_pkg

// ### verilog/ssd_disp_if.sv
// Display path between the status logic and the segment encoder
`timescale 1ns/1ps
`default_nettype none
interface ssd_disp_if;
	logic [7:0] code;
	logic       invert;
	logic [7:0] seg_hi;
	logic [7:0] seg_lo;
	modport ctrl (output code, output invert, input seg_hi, input seg_lo);
	modport enc  (input code, input invert, output seg_hi, output seg_lo);
endinterface : ssd_disp_if
`default_nettype wire

// ### verilog/ssd_scan_timer.sv
// Scan cycle divider: one-cycle tick per scan period
`timescale 1ns/1ps
`default_nettype none
module ssd_scan_timer #(
	parameter int PERIOD = ssd_pkg::SCAN_CYCLES
) (
	input  wire logic clock,
	input  wire logic reset,
	output logic      tick
);
	localparam int W = $clog2(PERIOD + 1);
	localparam logic [W-1:0] LAST = W'(PERIOD - 1);

	logic [W-1:0] count_reg;

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			count_reg <= '0;
			tick      <= 1'b0;
		end
		else
		begin
			tick      <= (count_reg == LAST);
			count_reg <= (count_reg == LAST) ? '0 : count_reg + 1'b1;
		end
	end
endmodule : ssd_scan_timer
`default_nettype wire

// ### verilog/ssd_seg_encoder.sv
// Two-digit seven-segment encoder with half-turn rotation
`timescale 1ns/1ps
`default_nettype none
module ssd_seg_encoder (
	ssd_disp_if.enc disp
);
	// ------------------------------------------------------------
	// Per-digit glyphs, bit order g f e d c b a
	// ------------------------------------------------------------
	for (genvar d = 0; d < 2; d++)
	begin : dig
		logic [6:0] raw;
		logic [7:0] seg;
		always_comb
		begin
			case (disp.code[d*4 +: 4])
				4'h0: raw = 7'h3f;
				4'h1: raw = 7'h06;
				4'h2: raw = 7'h5b;
				4'h3: raw = 7'h4f;
				4'h4: raw = 7'h66;
				4'h5: raw = 7'h6d;
				4'h6: raw = 7'h7d;
				4'h7: raw = 7'h07;
				4'h8: raw = 7'h7f;
				4'h9: raw = 7'h6f;
				4'ha: raw = 7'h77;
				4'hb: raw = 7'h7c;
				4'hc: raw = 7'h39;
				4'hd: raw = 7'h5e;
				4'he: raw = 7'h79;
				default: raw = 7'h71;
			endcase
		end
		// Half turn swaps a/d, b/e, c/f; dots mark the inverted view
		assign seg = disp.invert ? {1'b1, raw[6], raw[2:0], raw[5:3]} : {1'b0, raw};
	end

	// Rotation also swaps digit positions
	assign disp.seg_hi = disp.invert ? dig[0].seg : dig[1].seg;
	assign disp.seg_lo = disp.invert ? dig[1].seg : dig[0].seg;
endmodule : ssd_seg_encoder
`default_nettype wire

// ### verilog/ssd_top.sv
// Status display, network reset, card setup and scan gating of the scanner
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - In normal running show the selected area as 01 to 32.
// - After every restart show 00 while initializing, before any area code.
// - Interlock codes: 34 zone 1, 35 zone 2, 36 both zones.
// - Muting or override codes: 37 zone 1, 38 zone 2, 39 both.
// - Card setup shows F2 found, F3 applying, F4 await removal, F5 restart.
// - Finished address reset shows Fb, then the device restarts.
// - Any code outside the defined set means an error state.
// - Inverted setting rotates digits half a turn and lights both dots.
// - Switch held over 3 s in normal running restores network defaults, Fb, restart.
// - Defaults: 192.168.0.10, gateway 192.168.0.1, mask 255.255.255.0, port 10940.
// - Card settings taken only with matching serial and good password.
// - Laser-off mode: area 1 stops emission and forces safety outputs off.
// - Skip count 0 to 3; zero means every scan cycle measures.
// - Skip count N puts N dark cycles between measuring cycles.
// - Laser stays off throughout every skipped cycle.
// - Outputs hold their last measuring-cycle state during skipped cycles.
// - Scan cycle is 30 ms; area switch takes effect at next cycle.
module ssd_top #(
	parameter int SCAN_CYCLES_P = ssd_pkg::SCAN_CYCLES,
	parameter int HOLD_CYCLES_P = ssd_pkg::HOLD_CYCLES,
	parameter int INIT_SCANS_P  = ssd_pkg::INIT_SCANS
) (
	input  wire logic        clock,
	input  wire logic        reset,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output logic      [31:0] reg_rdata,
	input  wire logic [5:0]  area_select,
	input  wire logic [1:0]  zone_interlock,
	input  wire logic [1:0]  zone_muting,
	input  wire logic [1:0]  zone_clear,
	input  wire logic        error_valid,
	input  wire logic [3:0]  error_num,
	input  wire logic        init_switch,
	input  wire logic        card_inserted,
	input  wire logic        card_id_match,
	input  wire logic        card_pass_ok,
	input  wire logic [3:0]  card_config,
	input  wire logic        card_apply_done,
	output logic      [7:0]  seg_hi,
	output logic      [7:0]  seg_lo,
	output logic             laser_enable,
	output logic      [1:0]  safety_switching_output,
	output logic             restart_pulse,
	output logic             measuring
);
	localparam int HW = $clog2(HOLD_CYCLES_P + 1);
	localparam int IW = $clog2(INIT_SCANS_P + 1);
	localparam logic [HW-1:0] HOLD_LAST = HW'(HOLD_CYCLES_P);
	localparam logic [IW-1:0] INIT_LAST = IW'(INIT_SCANS_P - 1);

	ssd_pkg::ssd_phase_e phase_reg, phase_next;
	logic [3:0]    ctrl_reg, ctrl_next;
	logic [31:0]   ip_reg, gw_reg, mask_reg;
	logic [15:0]   port_reg;
	logic [HW-1:0] hold_reg;
	logic [IW-1:0] init_reg;
	logic [5:0]    area_reg;
	logic [1:0]    skip_reg;
	logic [7:0]    code_reg, code_next;
	logic          meas_next, lo_active, lo_next, scan_tick, accept, restore;

	ssd_disp_if disp ();

	ssd_scan_timer #(.PERIOD(SCAN_CYCLES_P)) u_timer (
		.clock (clock),
		.reset (reset),
		.tick  (scan_tick)
	);

	ssd_seg_encoder u_enc (
		.disp (disp)
	);

	// ------------------------------------------------------------
	// Phase sequencing
	// ------------------------------------------------------------
	assign accept  = card_inserted && card_id_match && card_pass_ok;
	assign restore = (phase_reg == ssd_pkg::PH_RUN) && (hold_reg == HOLD_LAST);

	always_comb
	begin
		phase_next = phase_reg;
		case (phase_reg)
			ssd_pkg::PH_INIT:
				if (scan_tick && init_reg == INIT_LAST)
					phase_next = ssd_pkg::PH_RUN;
			ssd_pkg::PH_RUN:
				if (restore)
					phase_next = ssd_pkg::PH_ADDR;
				else if (accept)
					phase_next = ssd_pkg::PH_FOUND;
			ssd_pkg::PH_FOUND:
				if (scan_tick)
					phase_next = ssd_pkg::PH_APPLY;
			ssd_pkg::PH_APPLY:
				if (card_apply_done)
					phase_next = ssd_pkg::PH_DONE;
			ssd_pkg::PH_DONE:
				if (!card_inserted)
					phase_next = ssd_pkg::PH_REST;
			ssd_pkg::PH_REST, ssd_pkg::PH_ADDR:
				if (scan_tick)
					phase_next = ssd_pkg::PH_INIT;
			default:
				phase_next = ssd_pkg::PH_INIT;
		endcase
	end

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			phase_reg     <= ssd_pkg::PH_INIT;
			restart_pulse <= 1'b0;
		end
		else
		begin
			phase_reg     <= phase_next;
			restart_pulse <= (phase_next == ssd_pkg::PH_INIT) && (phase_reg != ssd_pkg::PH_INIT);
		end
	end

	// Scans spent in the initializing phase
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
			init_reg <= '0;
		else if (phase_reg != ssd_pkg::PH_INIT)
			init_reg <= '0;
		else if (scan_tick)
			init_reg <= init_reg + 1'b1;
	end

	// Switch hold time; only counted while running normally
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
			hold_reg <= '0;
		else if (!init_switch || phase_reg != ssd_pkg::PH_RUN)
			hold_reg <= '0;
		else if (hold_reg != HOLD_LAST)
			hold_reg <= hold_reg + 1'b1;
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_comb
	begin
		ctrl_next = ctrl_reg;
		if (phase_reg == ssd_pkg::PH_FOUND && phase_next == ssd_pkg::PH_APPLY)
			ctrl_next = card_config;
		else if (reg_write && reg_addr == ssd_pkg::ADDR_CTRL)
			ctrl_next = reg_wdata[3:0];
	end

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
			ctrl_reg <= ssd_pkg::CTRL_RESET;
		else
			ctrl_reg <= ctrl_next;
	end

	// Restore beats a write landing in the same cycle
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			ip_reg   <= ssd_pkg::FACT_IP;
			gw_reg   <= ssd_pkg::FACT_GW;
			mask_reg <= ssd_pkg::FACT_MASK;
			port_reg <= ssd_pkg::FACT_PORT;
		end
		else if (restore)
		begin
			ip_reg   <= ssd_pkg::FACT_IP;
			gw_reg   <= ssd_pkg::FACT_GW;
			mask_reg <= ssd_pkg::FACT_MASK;
			port_reg <= ssd_pkg::FACT_PORT;
		end
		else if (reg_write)
		begin
			if (reg_addr == ssd_pkg::ADDR_IP)
				ip_reg <= reg_wdata;
			if (reg_addr == ssd_pkg::ADDR_GW)
				gw_reg <= reg_wdata;
			if (reg_addr == ssd_pkg::ADDR_MASK)
				mask_reg <= reg_wdata;
			if (reg_addr == ssd_pkg::ADDR_PORT)
				port_reg <= reg_wdata[15:0];
		end
	end

	// Read data stands for one cycle only, zero otherwise
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
			reg_rdata <= '0;
		else if (!reg_read)
			reg_rdata <= '0;
		else
			case (reg_addr)
				ssd_pkg::ADDR_CTRL:   reg_rdata <= {28'h0000000, ctrl_reg};
				ssd_pkg::ADDR_STATUS: reg_rdata <= {16'h0000, 1'b0, measuring,
					safety_switching_output, laser_enable, phase_reg, code_reg};
				ssd_pkg::ADDR_IP:     reg_rdata <= ip_reg;
				ssd_pkg::ADDR_GW:     reg_rdata <= gw_reg;
				ssd_pkg::ADDR_MASK:   reg_rdata <= mask_reg;
				ssd_pkg::ADDR_PORT:   reg_rdata <= {16'h0000, port_reg};
				default:              reg_rdata <= '0;
			endcase
	end

	// ------------------------------------------------------------
	// Scan gating
	// ------------------------------------------------------------
	// Area taken at cycle boundary, so a switch costs up to one cycle
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
			area_reg <= ssd_pkg::LOFF_AREA;
		else if (scan_tick)
			area_reg <= area_select;
	end

	assign lo_active = ctrl_reg[ssd_pkg::CTRL_LOFF] && area_reg == ssd_pkg::LOFF_AREA;
	// Next control value, so a fresh laser-off bit darkens without a lit cycle
	assign lo_next   = ctrl_next[ssd_pkg::CTRL_LOFF] &&
		(scan_tick ? area_select : area_reg) == ssd_pkg::LOFF_AREA;

	// Skip count shrinking mid-run restarts the pattern at once
	always_comb
	begin
		meas_next = measuring;
		if (scan_tick)
			meas_next = (skip_reg >= ctrl_reg[ssd_pkg::CTRL_SKIP +: 2]);
	end

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			skip_reg     <= 2'h0;
			measuring    <= 1'b1;
			laser_enable <= 1'b0;
		end
		else
		begin
			if (scan_tick)
				skip_reg <= meas_next ? 2'h0 : skip_reg + 2'h1;
			measuring    <= meas_next;
			laser_enable <= meas_next && !lo_next;
		end
	end

	// Outputs refresh at the end of a measuring cycle; a laser-off area clears them in any cycle
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
			safety_switching_output <= 2'h0;
		else if (lo_next)
			safety_switching_output <= 2'h0;
		else if (scan_tick && measuring)
			safety_switching_output <= zone_clear & ~zone_interlock;
	end

	// ------------------------------------------------------------
	// Display
	// ------------------------------------------------------------
	function automatic logic [7:0] area_bcd(input logic [5:0] a);
		logic [5:0] q;
		q = a / 6'h0a;
		return {q[3:0], 4'(a - 6'(q * 6'h0a))};
	endfunction : area_bcd

	always_comb
	begin
		code_next = area_bcd(area_reg);
		if (error_valid)
			code_next = {ssd_pkg::ERR_DIGIT, error_num};
		else
			case (phase_reg)
				ssd_pkg::PH_INIT:  code_next = ssd_pkg::CODE_INIT;
				ssd_pkg::PH_FOUND: code_next = ssd_pkg::CODE_FOUND;
				ssd_pkg::PH_APPLY: code_next = ssd_pkg::CODE_APPLY;
				ssd_pkg::PH_DONE:  code_next = ssd_pkg::CODE_DONE;
				ssd_pkg::PH_REST:  code_next = ssd_pkg::CODE_REST;
				ssd_pkg::PH_ADDR:  code_next = ssd_pkg::CODE_ADDR;
				default:
					if (zone_interlock == 2'h3)
						code_next = ssd_pkg::CODE_ILK12;
					else if (zone_interlock == 2'h1)
						code_next = ssd_pkg::CODE_ILK1;
					else if (zone_interlock == 2'h2)
						code_next = ssd_pkg::CODE_ILK2;
					else if (zone_muting == 2'h3)
						code_next = ssd_pkg::CODE_MUT12;
					else if (zone_muting == 2'h1)
						code_next = ssd_pkg::CODE_MUT1;
					else if (zone_muting == 2'h2)
						code_next = ssd_pkg::CODE_MUT2;
					else if (lo_active)
						code_next = ssd_pkg::CODE_LOFF;
					else if (area_reg == 6'h00 || area_reg > ssd_pkg::MAX_AREA)
						code_next = {ssd_pkg::ERR_DIGIT, 4'h0};
			endcase
	end

	assign disp.code   = code_reg;
	assign disp.invert = ctrl_reg[ssd_pkg::CTRL_INV];

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			code_reg <= ssd_pkg::CODE_INIT;
			seg_hi   <= 8'h00;
			seg_lo   <= 8'h00;
		end
		else
		begin
			code_reg <= code_next;
			seg_hi   <= disp.seg_hi;
			seg_lo   <= disp.seg_lo;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	sequence s_fb_leaving;
		phase_reg == ssd_pkg::PH_ADDR && scan_tick;
	endsequence

	sequence s_restarted;
		phase_reg == ssd_pkg::PH_INIT && restart_pulse;
	endsequence

	a_init_zero: assert property (
		phase_reg == ssd_pkg::PH_INIT && !error_valid |=> code_reg == ssd_pkg::CODE_INIT)
		else $error("init code not 00");
	a_ilk_both: assert property (
		phase_reg == ssd_pkg::PH_RUN && !error_valid && zone_interlock == 2'h3
		|=> code_reg == ssd_pkg::CODE_ILK12)
		else $error("both interlock code wrong");
	a_mut_both: assert property (
		phase_reg == ssd_pkg::PH_RUN && !error_valid && zone_interlock == 2'h0
		&& zone_muting == 2'h3 |=> code_reg == ssd_pkg::CODE_MUT12)
		else $error("both muting code wrong");
	a_fb_restart: assert property (
		s_fb_leaving |=> s_restarted)
		else $error("no restart after Fb");
	a_addr_defaults: assert property (
		phase_reg == ssd_pkg::PH_ADDR |-> ip_reg == ssd_pkg::FACT_IP
		&& port_reg == ssd_pkg::FACT_PORT)
		else $error("network defaults missing");
	a_card_reject: assert property (
		phase_reg == ssd_pkg::PH_RUN && !accept && !restore |=> $stable(ctrl_reg)
		|| $past(reg_write))
		else $error("rejected card changed settings");
	a_inv_dots: assert property (
		ctrl_reg[ssd_pkg::CTRL_INV] ##1 ctrl_reg[ssd_pkg::CTRL_INV] |=> seg_hi[7] && seg_lo[7])
		else $error("dots dark while inverted");
	a_loff_dark: assert property (
		lo_active |-> !laser_enable && safety_switching_output == 2'h0)
		else $error("laser-off area emitting");
	a_no_skip: assert property (
		scan_tick && ctrl_reg[ssd_pkg::CTRL_SKIP +: 2] == 2'h0 |=> measuring)
		else $error("skip zero but cycle skipped");
	a_skip_gap: assert property (
		scan_tick && measuring && ctrl_reg[ssd_pkg::CTRL_SKIP +: 2] != 2'h0 |=> !measuring)
		else $error("no skipped cycle after measure");
	a_skip_dark: assert property (
		!measuring |-> !laser_enable)
		else $error("laser on in skipped cycle");
	a_skip_hold: assert property (
		!measuring && !lo_next |=> $stable(safety_switching_output))
		else $error("outputs moved in skipped cycle");

endmodule : ssd_top
`default_nettype wire

// ### verif/ssd_operator.sv
// Operator model: reads the two-digit display and works the init switch
`timescale 1ns/1ps
`default_nettype none
module ssd_operator (
	input  wire logic       clock,
	input  wire logic [7:0] seg_hi,
	input  wire logic [7:0] seg_lo,
	output logic      [7:0] seen_code,
	output logic            seen_inv,
	output logic            init_switch
);
	function automatic logic [3:0] ssd_glyph(input logic [6:0] s);
		case (s)
			7'h3f: ssd_glyph = 4'h0;
			7'h06: ssd_glyph = 4'h1;
			7'h5b: ssd_glyph = 4'h2;
			7'h4f: ssd_glyph = 4'h3;
			7'h66: ssd_glyph = 4'h4;
			7'h6d: ssd_glyph = 4'h5;
			7'h7d: ssd_glyph = 4'h6;
			7'h07: ssd_glyph = 4'h7;
			7'h7f: ssd_glyph = 4'h8;
			7'h6f: ssd_glyph = 4'h9;
			7'h77: ssd_glyph = 4'ha;
			7'h39: ssd_glyph = 4'hc;
			7'h5e: ssd_glyph = 4'hd;
			7'h7c: ssd_glyph = 4'hb;
			7'h79: ssd_glyph = 4'he;
			7'h71: ssd_glyph = 4'hf;
			default: ssd_glyph = 4'hx;
		endcase
	endfunction : ssd_glyph
	// Half-turn swaps a-d, b-e, c-f; g stays
	function automatic logic [6:0] ssd_unrot(input logic [7:0] s);
		ssd_unrot = {s[6], s[2], s[1], s[0], s[5], s[4], s[3]};
	endfunction : ssd_unrot
	// Both dots lit means upside-down view; digits swap places too
	assign seen_inv = seg_hi[7] & seg_lo[7];
	assign seen_code = seen_inv ?
		{ssd_glyph(ssd_unrot(seg_lo)), ssd_glyph(ssd_unrot(seg_hi))} :
		{ssd_glyph(seg_hi[6:0]), ssd_glyph(seg_lo[6:0])};
	initial init_switch = 1'b0;
	// Pin held for a chosen number of cycles, then let go
	task automatic hold(input int n);
		init_switch <= 1'b1;
		repeat (n) @(posedge clock);
		init_switch <= 1'b0;
	endtask : hold
endmodule : ssd_operator
`default_nettype wire

// ### verif/ssd_top_tb.sv
// Self-checking bench for the status display and scan gating
`timescale 1ns/1ps
`default_nettype none
module ssd_top_tb;
	localparam int SCAN = 20;
	localparam int HOLD = 50;
	localparam int INIT = 2;
	logic        clock = 1'b0;
	logic        reset, reg_write, reg_read, error_valid, init_switch;
	logic        card_inserted, card_id_match, card_pass_ok, card_apply_done;
	logic [7:0]  reg_addr, seg_hi, seg_lo, seen_code;
	logic [31:0] reg_wdata, reg_rdata, obs, mon_m;
	logic [5:0]  area_select;
	logic [1:0]  zone_interlock, zone_muting, zone_clear, sso, sso_d;
	logic [3:0]  error_num, card_config;
	logic        laser_enable, restart_pulse, measuring, seen_inv;
	logic        rd_d = 1'b0, look = 1'b0, mea_d, gate16 = 1'b0;
	logic [31:0] exp_q[$], msk_q[$];
	int          err_total = 0, n_compared = 0, meas_cnt = 0, rst_cnt = 0;
	int          a, c0;

	always #10 clock = ~clock;

	ssd_top #(.SCAN_CYCLES_P(SCAN), .HOLD_CYCLES_P(HOLD), .INIT_SCANS_P(INIT)) DUT (
		.clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.area_select(area_select), .zone_interlock(zone_interlock),
		.zone_muting(zone_muting), .zone_clear(zone_clear), .error_valid(error_valid),
		.error_num(error_num), .init_switch(init_switch), .card_inserted(card_inserted),
		.card_id_match(card_id_match), .card_pass_ok(card_pass_ok),
		.card_config(card_config), .card_apply_done(card_apply_done),
		.seg_hi(seg_hi), .seg_lo(seg_lo), .laser_enable(laser_enable),
		.safety_switching_output(sso), .restart_pulse(restart_pulse),
		.measuring(measuring));

	ssd_operator OP (.clock(clock), .seg_hi(seg_hi), .seg_lo(seg_lo),
		.seen_code(seen_code), .seen_inv(seen_inv), .init_switch(init_switch));

	// ----------------------------------------
	// Compare, report, close
	// ----------------------------------------
	task automatic check(input logic [31:0] v, input logic [31:0] e);
		n_compared++;
		if (v !== e)
		begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h", $time, v, e);
		end
	endtask : check

	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done

	// ----------------------------------------
	// Drivers; each leaves a free edge before the next
	// ----------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask : cyc

	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		reg_addr <= ad;
		reg_wdata <= d;
		reg_write <= 1'b1;
		cyc(1);
		reg_write <= 1'b0;
		cyc(1);
	endtask : wr

	task automatic rd(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] e);
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		reg_addr <= ad;
		reg_read <= 1'b1;
		cyc(1);
		reg_read <= 1'b0;
		cyc(1);
	endtask : rd

	task automatic note(input logic [31:0] v, input logic [31:0] e);
		exp_q.push_back(e);
		msk_q.push_back(32'hffffffff);
		obs <= v;
		look <= 1'b1;
		cyc(1);
		look <= 1'b0;
		cyc(1);
	endtask : note

	// Bounded wait for a code on the display, then noted
	task automatic see(input logic [7:0] c, input int lim);
		int i;
		for (i = 0; i < lim && seen_code !== c; i++)
			cyc(1);
		note({24'h0, seen_code}, {24'h0, c});
	endtask : see

	// ----------------------------------------
	// Monitor
	// ----------------------------------------
	always @(posedge clock)
	begin
		if (rd_d || look)
		begin
			mon_m = msk_q.pop_front();
			check((rd_d ? reg_rdata : obs) & mon_m, exp_q.pop_front());
		end
		if (measuring === 1'b0)
			check({31'h0, laser_enable}, 32'h0);
		if (gate16 && sso !== sso_d)
			check({31'h0, mea_d}, 32'h1);
		if (restart_pulse === 1'b1)
			rst_cnt++;
		sso_d = sso;
		mea_d = measuring;
		meas_cnt <= meas_cnt + int'(measuring);
		rd_d <= reg_read;
		if (gate16)
			zone_clear <= 2'($urandom);
	end

	initial
	begin
		repeat (30000) @(posedge clock);
		err_total++;
		test_done();
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial
	begin
		void'($urandom(95931));
		{reset, reg_write, reg_read, error_valid, card_apply_done} = 5'h10;
		{card_inserted, card_id_match, card_pass_ok} = 3'h0;
		{zone_interlock, zone_muting, error_num, card_config} = 12'h0;
		{reg_addr, reg_wdata, zone_clear} = 42'h0;
		area_select = 6'h12;
		cyc(6);
		reset <= 1'b0;
		rd(ssd_pkg::ADDR_STATUS, 32'h7ff, 32'h0);
		rd(ssd_pkg::ADDR_IP, 32'hffffffff, ssd_pkg::FACT_IP);
		rd(ssd_pkg::ADDR_GW, 32'hffffffff, ssd_pkg::FACT_GW);
		rd(ssd_pkg::ADDR_MASK, 32'hffffffff, ssd_pkg::FACT_MASK);
		rd(ssd_pkg::ADDR_PORT, 32'hffff, 32'(ssd_pkg::FACT_PORT));
		rd(8'h18, 32'hffffffff, 32'h0);
		see(8'h18, (INIT + 3) * SCAN);
		for (int k = 0; k < 5; k++)
		begin
			a = (k == 0) ? 32 : $urandom_range(32, 1);
			area_select <= 6'(a);
			cyc(SCAN + 4);
			rd(ssd_pkg::ADDR_STATUS, 32'hff, 32'((a / 10) * 16 + a % 10));
		end
		area_select <= 6'h0c;
		zone_muting <= 2'h3;
		for (int k = 1; k < 4; k++)
		begin
			zone_interlock <= 2'(k);
			cyc(4);
			rd(ssd_pkg::ADDR_STATUS, 32'hff, 32'(8'h33 + k));
		end
		zone_interlock <= 2'h0;
		for (int k = 1; k < 4; k++)
		begin
			zone_muting <= 2'(k);
			cyc(4);
			rd(ssd_pkg::ADDR_STATUS, 32'hff, 32'(8'h36 + k));
		end
		error_num <= 4'($urandom);
		error_valid <= 1'b1;
		zone_interlock <= 2'h3;
		cyc(4);
		rd(ssd_pkg::ADDR_STATUS, 32'hff, {24'h0, 4'he, error_num});
		{error_valid, zone_muting, zone_interlock} <= 5'h1;
		wr(ssd_pkg::ADDR_CTRL, 32'h1);
		see(8'h34, 6);
		note({31'h0, seen_inv}, 32'h1);
		wr(ssd_pkg::ADDR_CTRL, 32'h0);
		cyc(4);
		note({31'h0, seen_inv}, 32'h0);
		zone_interlock <= 2'h0;
		gate16 <= 1'b1;
		for (int n = 0; n < 4; n++)
		begin
			wr(ssd_pkg::ADDR_CTRL, 32'(n << 2));
			cyc(8 * SCAN);
			c0 = meas_cnt;
			cyc(4 * (n + 1) * SCAN);
			note(32'(meas_cnt - c0), 32'(4 * SCAN));
		end
		gate16 <= 1'b0;
		wr(ssd_pkg::ADDR_CTRL, 32'h0);
		zone_clear <= 2'h3;
		cyc(2 * SCAN + 4);
		rd(ssd_pkg::ADDR_STATUS, 32'h7800, 32'h7800);
		zone_interlock <= 2'h1;
		cyc(2 * SCAN + 4);
		rd(ssd_pkg::ADDR_STATUS, 32'h3000, 32'h2000);
		zone_interlock <= 2'h0;
		wr(ssd_pkg::ADDR_CTRL, 32'h2);
		area_select <= 6'h01;
		cyc(2 * SCAN + 4);
		rd(ssd_pkg::ADDR_STATUS, 32'h38ff, 32'h0040);
		area_select <= 6'h0c;
		cyc(2 * SCAN + 4);
		rd(ssd_pkg::ADDR_STATUS, 32'h38ff, 32'h3812);
		wr(ssd_pkg::ADDR_CTRL, 32'h0);
		card_config <= 4'($urandom) & 4'hd;
		card_inserted <= 1'b1;
		for (int k = 0; k < 2; k++)
		begin
			{card_id_match, card_pass_ok} <= k ? 2'h2 : 2'h1;
			cyc(2 * SCAN);
			rd(ssd_pkg::ADDR_STATUS, 32'h7ff, 32'h112);
			rd(ssd_pkg::ADDR_CTRL, 32'hf, 32'h0);
		end
		{card_id_match, card_pass_ok} <= 2'h3;
		see(8'hf2, 6);
		see(8'hf3, SCAN + 4);
		card_apply_done <= 1'b1;
		cyc(1);
		card_apply_done <= 1'b0;
		see(8'hf4, 6);
		rd(ssd_pkg::ADDR_CTRL, 32'hf, {28'h0, card_config});
		card_inserted <= 1'b0;
		see(8'hf5, 6);
		see(8'h00, SCAN + 4);
		see(8'h12, (INIT + 3) * SCAN);
		wr(ssd_pkg::ADDR_CTRL, 32'h0);
		wr(ssd_pkg::ADDR_IP, 32'h01020304);
		rd(ssd_pkg::ADDR_IP, 32'hffffffff, 32'h01020304);
		OP.hold(HOLD - 5);
		cyc(4);
		rd(ssd_pkg::ADDR_STATUS, 32'h7ff, 32'h112);
		fork
			OP.hold(HOLD + 5);
			see(8'hfb, HOLD + 8);
		join
		see(8'h00, SCAN + 4);
		rd(ssd_pkg::ADDR_IP, 32'hffffffff, ssd_pkg::FACT_IP);
		see(8'h12, (INIT + 3) * SCAN);
		note(32'(rst_cnt), 32'h2);
		test_done();
	end
endmodule : ssd_top_tb
`default_nettype wire
